// ==== bench/dct_bus_model.sv ====
// cpu bus model: cycles to one address, direction alternating, data counting
`default_nettype none
module dct_bus_model #(
  parameter logic [15:0] ADDR = 16'h1234
) (
  // control
  input wire logic clk_sys,
  input wire logic go,
  // observed cpu bus
  output logic bus_cycle,
  output logic bus_read,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_data,
  output logic opcode_fetch,
  output logic opcode_exec,
  output logic [15:0] opcode_exec_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] k_r = 8'h00;
  always @(posedge clk_sys)
    k_r <= go ? k_r + 8'h01 : 8'h00;
  // idle address and data show inverted values, never a stale copy
  assign bus_cycle = go;
  assign bus_read = k_r[0];
  assign bus_addr = go ? ADDR : ~ADDR;
  assign bus_data = go ? k_r : ~k_r;
  assign opcode_fetch = go;
  assign opcode_exec = go;
  assign opcode_exec_addr = bus_addr;
endmodule // dct_bus_model
`default_nettype wire

// ==== bench/dct_checker.sv ====
// port assertions for the debug compare and trace block
`default_nettype none
module dct_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register access
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_background,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic mcu_secure,
  // results
  input wire logic force_reset_req,
  input wire logic break_req,
  input wire logic break_tag,
  input wire logic run_active_flag,
  input wire logic [3:0] valid_word_count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  wire logic frc_go = reg_wr && reg_addr == 4'hf && reg_from_background && reg_wdata[0];
  wire logic ctl_wr = reg_wr && reg_addr == 4'h8;
  property p_frc_src;
    force_reset_req |-> $past(frc_go);
  endproperty
  a_frc_src: assert property (p_frc_src) else $error("reset request without host write");
  property p_frc_go;
    frc_go |=> force_reset_req ##1 (force_reset_req == $past(frc_go));
  endproperty
  a_frc_go: assert property (p_frc_go) else $error("reset request missing");
  property p_frc_rd;
    reg_rd && reg_addr == 4'hf |=> reg_rdata == 8'h00;
  endproperty
  a_frc_rd: assert property (p_frc_rd) else $error("force register read not zero");
  property p_cnt;
    valid_word_count <= 4'h8;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count above full");
  property p_hold;
    !run_active_flag && $past(!run_active_flag) |-> $stable(valid_word_count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while idle");
  property p_tag;
    ctl_wr |=> break_tag == $past(reg_wdata[5]);
  endproperty
  a_tag: assert property (p_tag) else $error("break type not taken");
  property p_sec;
    ctl_wr && mcu_secure |=> !run_active_flag;
  endproperty
  a_sec: assert property (p_sec) else $error("armed while secured");
  property p_stop;
    ctl_wr && !(reg_wdata[7] && reg_wdata[6]) |=> !run_active_flag;
  endproperty
  a_stop: assert property (p_stop) else $error("run not stopped");
  property p_brk;
    break_req |-> !run_active_flag ##1 !break_req;
  endproperty
  a_brk: assert property (p_brk) else $error("break request while armed");
endmodule // dct_checker
bind dct_debug_trace dct_checker dct_checker_inst (.clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_from_background, .reg_wdata, .reg_rdata, .mcu_secure, .force_reset_req, .break_req,
  .break_tag, .run_active_flag, .valid_word_count);
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the debug compare and trace block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_bg = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] trigger_mode = 4'h3;
  logic mcu_secure = 1'b0;
  logic go = 1'b0;
  logic trace_begin = 1'b0;
  logic opcode_execution_qualify = 1'b0;
  int n_brk = 0;
  logic bus_cycle, bus_read, opcode_fetch, opcode_exec, force_reset_req, break_req, break_tag;
  logic run_active_flag, match_a_flag, match_b_flag;
  logic [15:0] bus_addr, opcode_exec_addr;
  logic [7:0] bus_data, reg_rdata;
  logic [3:0] valid_word_count;
  int mismatches = 0;
  int n_compared = 0;
  dct_bus_model dct_bus_model_inst (.clk_sys, .go, .bus_cycle, .bus_read, .bus_addr, .bus_data,
    .opcode_fetch, .opcode_exec, .opcode_exec_addr);
  dct_debug_trace dct_debug_trace_inst (.clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_from_background(reg_bg), .reg_wdata, .reg_rdata, .bus_cycle, .bus_read, .bus_addr,
    .bus_data, .opcode_fetch, .opcode_exec, .opcode_exec_addr, .trigger_mode, .trace_begin,
    .opcode_execution_qualify, .mcu_secure, .force_reset_req, .break_req, .break_tag,
    .run_active_flag, .valid_word_count, .match_a_flag, .match_b_flag);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (break_req === 1'b1)
      n_brk <= n_brk + 1;
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic bg);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = v;
    reg_bg = bg;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_bg = 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  // let the bus run until the capture run ends, with a bounded wait
  task automatic run_bus;
    go = 1'b1;
    for (int i = 0; i < 100 && run_active_flag === 1'b1; i++) @(negedge clk_sys);
    go = 1'b0;
    if (run_active_flag !== 1'b0)
    begin
      mismatches++;
      $display("[FAIL] %0t capture run did not end", $time);
    end
    repeat (2) @(negedge clk_sys);
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) rdc(i[3:0], 8'h00);
    rdc(4'h6, 8'h00);
    wr(4'hf, 8'h01, 1'b0);
    chkf(force_reset_req, 1'b0);
    wr(4'hf, 8'h01, 1'b1);
    chkf(force_reset_req, 1'b1);
    rdc(4'hf, 8'h00);
    mcu_secure = 1'b1;
    wr(4'h8, 8'hc0, 1'b0);
    chkf(run_active_flag, 1'b0);
    mcu_secure = 1'b0;
    $display("test regs done");
    for (int i = 0; i < 4; i++) wr(i[3:0], i[0] ? 8'h34 : 8'h12, 1'b0);
    wr(4'h8, 8'hd7, 1'b0);
    chkf(run_active_flag, 1'b1);
    wr(4'h0, 8'hff, 1'b0);
    wr(4'h4, 8'haa, 1'b0);
    rdc(4'h0, 8'h12);
    rdc(4'h8, 8'hd7);
    run_bus;
    chk(n_brk[7:0], 8'h01);
    chkf(break_tag, 1'b0);
    chk({4'h0, valid_word_count}, 8'h08);
    chkf(match_a_flag, 1'b1);
    chkf(match_b_flag, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      rdc(4'h4, 8'h00);
      rdc(4'h5, 8'(2 * i + 1));
    end
    trigger_mode = 4'h0;
    rdc(4'h4, 8'h12);
    rdc(4'h5, 8'h34);
    $display("test capture done");
    wr(4'h8, 8'hc0, 1'b0);
    chkf(run_active_flag, 1'b1);
    wr(4'h8, 8'ha0, 1'b0);
    chkf(run_active_flag, 1'b0);
    chkf(break_tag, 1'b1);
    rdc(4'h5, 8'h00);
    chk({4'h0, valid_word_count}, 8'h00);
    $display("test stop done");
    trace_begin = 1'b1;
    opcode_execution_qualify = 1'b1;
    wr(4'h8, 8'hd0, 1'b0);
    run_bus;
    chk({4'h0, valid_word_count}, 8'h08);
    chk(n_brk[7:0], 8'h02);
    trace_begin = 1'b0;
    opcode_execution_qualify = 1'b0;
    wr(4'h8, 8'hcc, 1'b0);
    run_bus;
    chk({4'h0, valid_word_count}, 8'h02);
    chk(n_brk[7:0], 8'h02);
    $display("test trace modes done");
    final_report;
  end
endmodule // tb
`default_nettype wire

// ==== hw/dct_debug_trace.v ====
// debug compare and trace block: comparators, capture fifo, control and forced reset
// Operation
// RULE_01: user writes to force register are ignored
// RULE_02: force register always reads zero
// RULE_03: background write of bit0 forces reset
// RULE_04: nine user-visible bytes of register space; the code decodes eight offsets: 0-5, 8 and F
// RULE_05: comparator bytes reset zero, locked while armed
// RULE_06: fifo high port read-only, zero event-only
// RULE_07: high read holds, low read advances
// RULE_08: event-only modes store bytes only
// RULE_09: low reads never advance while armed
// RULE_10: host waits for run end before reading
// RULE_11: unarmed low read stores last opcode address
// RULE_12: ninth profiling read returns first stored
// RULE_13: control register always readable and writable
// RULE_14: enable bit refuses set while secured
// RULE_15: bit6 arms; completion or zero stops
// RULE_16: bit5 picks force or tag break
// RULE_17: bit4 issues breaks at end or full
// RULE_18: opcode qualification leaves break timing alone
// RULE_19: comparator A direction qualified by bits 3:2
// RULE_20: comparator B direction qualified by bits 1:0
// RULE_21: run ends on full or end trigger
// RULE_22: at most eight words, count reads 8
// RULE_23: comparators join bytes, compare full address
// RULE_24: empty fifo read returns zero harmlessly
`include "dct_defs.vh"
`default_nettype none

module dct_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  input wire flush,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire full,
  output wire empty
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  genvar gi;

  assign empty = (cnt_r == {(AW+1){1'b0}});
  assign full = (cnt_r == DEPTH[AW:0]);
  assign out_valid = !empty;
  // a simultaneous pop frees the slot, so a full fifo still accepts
  assign in_ready = !full || out_ready;
  assign pop = out_valid && out_ready;
  assign push = in_valid && in_ready;
  assign out_data = empty ? {WIDTH{1'b0}} : mem_r[rd_ptr_r];

  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_entry
      always @(posedge clk_sys)
      begin
        if (!reset_n)
          mem_r[gi] <= {WIDTH{1'b0}};
        else if (push && wr_ptr_r == gi[AW-1:0])
          mem_r[gi] <= in_data;
      end
    end
  endgenerate

  always @(posedge clk_sys)
  begin
    if (!reset_n || flush)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // dct_fifo

module dct_debug_trace #(
  parameter FIFO_WORDS = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // register access from cpu or background commands
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_from_background,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // cpu bus observation
  input wire bus_cycle,
  input wire bus_read,
  input wire [15:0] bus_addr,
  input wire [7:0] bus_data,
  input wire opcode_fetch,
  input wire opcode_exec,
  input wire [15:0] opcode_exec_addr,
  // trigger setup and security
  input wire [3:0] trigger_mode,
  input wire trace_begin,
  input wire opcode_execution_qualify,
  input wire mcu_secure,
  // results
  output reg force_reset_req,
  output reg break_req,
  output reg break_tag,
  output wire run_active_flag,
  output reg [3:0] valid_word_count,
  output reg match_a_flag,
  output reg match_b_flag
);
  reg [7:0] cmp_a_high_r;
  reg [7:0] cmp_a_low_r;
  reg [7:0] cmp_b_high_r;
  reg [7:0] cmp_b_low_r;
  reg [7:0] control_r;
  reg [7:0] control_nxt;
  reg [15:0] last_opcode_r;
  reg triggered_r;
  reg a_seen_r;
  wire [15:0] cmp_a;
  wire [15:0] cmp_b;
  wire armed;
  wire wr_any;
  wire rd_fifo_low;
  wire event_only;
  wire [15:0] match_addr;
  wire match_cycle;
  wire hit_a;
  wire hit_b;
  wire dir_a_ok;
  wire dir_b_ok;
  wire data_b_hit;
  reg trigger_hit;
  wire end_trigger;
  wire store_req;
  wire store_ok;
  wire [15:0] store_word;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [15:0] fifo_in_data;
  wire fifo_out_ready;
  wire [15:0] fifo_out_data;
  wire fifo_full;
  wire fifo_flush;
  wire run_done;
  wire arm_start;
  wire full_now;

  assign cmp_a = {cmp_a_high_r, cmp_a_low_r}; // RULE_23
  assign cmp_b = {cmp_b_high_r, cmp_b_low_r}; // RULE_23
  assign armed = control_r[`DCT_CTL_ARM] && control_r[`DCT_CTL_ENABLE];
  assign run_active_flag = armed; // RULE_15
  assign wr_any = reg_wr;
  assign rd_fifo_low = reg_rd && reg_addr == `DCT_OFS_FIFO_LOW;
  assign event_only = trigger_mode == `DCT_TRG_EVENT_B || trigger_mode == `DCT_TRG_A_THEN_EVENT_B;

  // qualified triggers watch executed opcodes; otherwise every bus cycle
  assign match_cycle = opcode_execution_qualify ? opcode_exec : bus_cycle;
  assign match_addr = opcode_execution_qualify ? opcode_exec_addr : bus_addr;
  assign dir_a_ok = !control_r[`DCT_CTL_RW_A_EN] || (bus_read == control_r[`DCT_CTL_RW_A]); // RULE_19
  assign dir_b_ok = !control_r[`DCT_CTL_RW_B_EN] || (bus_read == control_r[`DCT_CTL_RW_B]); // RULE_20
  assign hit_a = match_cycle && dir_a_ok && match_addr == cmp_a; // RULE_23
  assign hit_b = match_cycle && dir_b_ok && match_addr == cmp_b; // RULE_23
  assign data_b_hit = bus_cycle && dir_b_ok && bus_data == cmp_b_low_r;

  always @*
  begin
    case (trigger_mode)
      `DCT_TRG_A_ONLY: trigger_hit = hit_a;
      `DCT_TRG_A_OR_B: trigger_hit = hit_a || hit_b;
      `DCT_TRG_A_THEN_B: trigger_hit = a_seen_r && hit_b;
      `DCT_TRG_EVENT_B: trigger_hit = hit_b;
      `DCT_TRG_A_THEN_EVENT_B: trigger_hit = a_seen_r && hit_b;
      `DCT_TRG_A_AND_B_DATA: trigger_hit = hit_a && data_b_hit;
      `DCT_TRG_A_AND_NOT_B_DATA: trigger_hit = hit_a && !data_b_hit;
      `DCT_TRG_INSIDE: trigger_hit = match_cycle && match_addr >= cmp_a && match_addr <= cmp_b;
      `DCT_TRG_OUTSIDE: trigger_hit = match_cycle && (match_addr < cmp_a || match_addr > cmp_b);
      default: trigger_hit = 1'b0;
    endcase
  end

  // event-only modes always run as begin traces and store one event byte per hit
  assign end_trigger = armed && !event_only && !trace_begin && trigger_hit;
  assign store_req = event_only ? (armed && trigger_hit)
                   : (armed && opcode_fetch && (trace_begin ? (triggered_r || trigger_hit) : 1'b1));
  assign store_word = event_only ? {8'h00, bus_data} : bus_addr; // RULE_08
  assign full_now = valid_word_count == `DCT_FULL_COUNT;
  assign store_ok = store_req && !full_now && fifo_in_ready;
  assign run_done = end_trigger || (armed && (event_only || trace_begin) && full_now); // RULE_21

  // unarmed low reads push the last opcode address while popping the head
  assign fifo_in_valid = armed ? (store_req && (!(event_only || trace_begin) || !full_now)) : rd_fifo_low; // RULE_11
  assign fifo_in_data = armed ? store_word : last_opcode_r; // RULE_11
  // end traces drop the oldest word to run circular; armed reads never pop
  assign fifo_out_ready = armed ? (store_req && fifo_full && !trace_begin && !event_only) : rd_fifo_low; // RULE_09 RULE_12
  assign arm_start = wr_any && reg_addr == `DCT_OFS_CONTROL && !armed && control_nxt[`DCT_CTL_ARM];
  assign fifo_flush = arm_start;

  dct_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty()
  );

  // control register next value
  always @*
  begin
    control_nxt = control_r;
    if (wr_any && reg_addr == `DCT_OFS_CONTROL) // RULE_13
    begin
      control_nxt = reg_wdata;
      if (mcu_secure)
        control_nxt[`DCT_CTL_ENABLE] = 1'b0; // RULE_14
      if (!control_nxt[`DCT_CTL_ENABLE])
        control_nxt[`DCT_CTL_ARM] = 1'b0; // RULE_15
    end
    else if (run_done)
      control_nxt[`DCT_CTL_ARM] = 1'b0; // RULE_15
  end

  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      control_r <= `DCT_RST_BYTE;
      cmp_a_high_r <= `DCT_RST_BYTE; // RULE_05
      cmp_a_low_r <= `DCT_RST_BYTE;
      cmp_b_high_r <= `DCT_RST_BYTE;
      cmp_b_low_r <= `DCT_RST_BYTE;
      last_opcode_r <= `DCT_RST_WORD;
      triggered_r <= 1'b0;
      a_seen_r <= 1'b0;
      valid_word_count <= 4'h0;
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
      force_reset_req <= 1'b0;
      break_req <= 1'b0;
      break_tag <= 1'b0;
    end
    else
    begin
      control_r <= control_nxt;
      if (wr_any && !armed) // RULE_05
      begin
        if (reg_addr == `DCT_OFS_CMP_A_HIGH)
          cmp_a_high_r <= reg_wdata;
        if (reg_addr == `DCT_OFS_CMP_A_LOW)
          cmp_a_low_r <= reg_wdata;
        if (reg_addr == `DCT_OFS_CMP_B_HIGH)
          cmp_b_high_r <= reg_wdata;
        if (reg_addr == `DCT_OFS_CMP_B_LOW)
          cmp_b_low_r <= reg_wdata;
      end
      if (opcode_fetch)
        last_opcode_r <= bus_addr;
      // force register: only a background write reaches the reset request
      force_reset_req <= wr_any && reg_addr == `DCT_OFS_FORCE_RESET && reg_from_background
                         && reg_wdata[`DCT_FRC_BIT]; // RULE_01 RULE_03
      if (arm_start)
      begin
        valid_word_count <= 4'h0;
        triggered_r <= 1'b0;
        a_seen_r <= 1'b0;
        match_a_flag <= 1'b0;
        match_b_flag <= 1'b0;
      end
      else if (armed)
      begin
        if (store_ok)
          valid_word_count <= valid_word_count + 4'h1; // RULE_22
        if (trigger_hit)
          triggered_r <= 1'b1;
        if (hit_a)
        begin
          a_seen_r <= 1'b1;
          match_a_flag <= 1'b1;
        end
        if (hit_b)
          match_b_flag <= 1'b1;
      end
      // breaks follow the run end, independent of opcode qualification
      break_req <= control_r[`DCT_CTL_BRK_EN] && run_done && !(wr_any && reg_addr == `DCT_OFS_CONTROL); // RULE_17 RULE_18
      break_tag <= control_nxt[`DCT_CTL_TAG]; // RULE_16
    end
  end

  // read data registered one cycle after the read strobe
  always @(posedge clk_sys)
  begin
    if (!reset_n)
      reg_rdata <= `DCT_READ_ZERO;
    else if (reg_rd) // RULE_04
    begin
      case (reg_addr)
        `DCT_OFS_CMP_A_HIGH: reg_rdata <= cmp_a_high_r;
        `DCT_OFS_CMP_A_LOW: reg_rdata <= cmp_a_low_r;
        `DCT_OFS_CMP_B_HIGH: reg_rdata <= cmp_b_high_r;
        `DCT_OFS_CMP_B_LOW: reg_rdata <= cmp_b_low_r;
        `DCT_OFS_FIFO_HIGH: reg_rdata <= event_only ? `DCT_READ_ZERO : fifo_out_data[15:8]; // RULE_06 RULE_07
        `DCT_OFS_FIFO_LOW: reg_rdata <= fifo_out_data[7:0]; // RULE_07 RULE_24
        `DCT_OFS_CONTROL: reg_rdata <= control_r; // RULE_13
        `DCT_OFS_FORCE_RESET: reg_rdata <= `DCT_READ_ZERO; // RULE_02
        default: reg_rdata <= `DCT_READ_ZERO;
      endcase
    end
  end
endmodule // dct_debug_trace

`default_nettype wire

// ==== pkg/dct_defs.vh ====
// register offsets, field positions, reset values and mode codes of the debug compare and trace block
`ifndef DCT_DEFS_VH
`define DCT_DEFS_VH

`define DCT_OFS_CMP_A_HIGH 4'h0
`define DCT_OFS_CMP_A_LOW 4'h1
`define DCT_OFS_CMP_B_HIGH 4'h2
`define DCT_OFS_CMP_B_LOW 4'h3
`define DCT_OFS_FIFO_HIGH 4'h4
`define DCT_OFS_FIFO_LOW 4'h5
`define DCT_OFS_CONTROL 4'h8
`define DCT_OFS_FORCE_RESET 4'hf

`define DCT_CTL_ENABLE 7
`define DCT_CTL_ARM 6
`define DCT_CTL_TAG 5
`define DCT_CTL_BRK_EN 4
`define DCT_CTL_RW_A 3
`define DCT_CTL_RW_A_EN 2
`define DCT_CTL_RW_B 1
`define DCT_CTL_RW_B_EN 0
`define DCT_FRC_BIT 0

`define DCT_RST_BYTE 8'h00
`define DCT_RST_WORD 16'h0000
`define DCT_READ_ZERO 8'h00
`define DCT_FULL_COUNT 4'h8

`define DCT_TRG_A_ONLY 4'h0
`define DCT_TRG_A_OR_B 4'h1
`define DCT_TRG_A_THEN_B 4'h2
`define DCT_TRG_EVENT_B 4'h3
`define DCT_TRG_A_THEN_EVENT_B 4'h4
`define DCT_TRG_A_AND_B_DATA 4'h5
`define DCT_TRG_A_AND_NOT_B_DATA 4'h6
`define DCT_TRG_INSIDE 4'h7
`define DCT_TRG_OUTSIDE 4'h8

`endif
